// ---- tb/ofd_core_assertions.sv ----
// bus handshake assertions for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_core_checker (
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_rstn,
	// write channels
	input wire logic [7:0]  i_s_axi_awaddr,
	input wire logic        i_s_axi_awvalid,
	input wire logic        o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0]  i_s_axi_wstrb,
	input wire logic        i_s_axi_wvalid,
	input wire logic        o_s_axi_wready,
	input wire logic [1:0]  o_s_axi_bresp,
	input wire logic        o_s_axi_bvalid,
	input wire logic        i_s_axi_bready,
	// read channels
	input wire logic [7:0]  i_s_axi_araddr,
	input wire logic        i_s_axi_arvalid,
	input wire logic        o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0]  o_s_axi_rresp,
	input wire logic        o_s_axi_rvalid,
	input wire logic        i_s_axi_rready
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	wire wtk = i_s_axi_awvalid && o_s_axi_awready;
	wire rtk = i_s_axi_arvalid && o_s_axi_arready;
	// ==========================================================
	// write side
	a_wr_ready_term: assert property (o_s_axi_wready == o_s_axi_awready
		&& o_s_axi_awready == (i_s_axi_awvalid && i_s_axi_wvalid
		&& !o_s_axi_bvalid)) else $error("write ready wrong");
	a_wr_answer: assert property (wtk |=> o_s_axi_bvalid)
		else $error("write answer late");
	a_wr_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
		o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bresp moved");
	a_wr_err_code: assert property (wtk && i_s_axi_awaddr[7:6] != 2'h0
		|=> o_s_axi_bresp == 2'h2) else $error("write error code");
	a_wr_release: assert property (o_s_axi_bvalid && i_s_axi_bready
		|=> !o_s_axi_bvalid) else $error("bvalid stuck");
	// ==========================================================
	// read side
	a_rd_ready_term: assert property (o_s_axi_arready ==
		(i_s_axi_arvalid && !o_s_axi_rvalid)) else $error("read ready wrong");
	a_rd_answer: assert property (rtk |=> o_s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
		o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata moved");
	a_rd_err_code: assert property (rtk && i_s_axi_araddr[7:6] != 2'h0 |=>
		o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0)
		else $error("read error code");
endmodule
bind ofd_core ofd_core_checker ofd_core_checker_inst (.*);
`default_nettype wire

// ---- tb/ofd_fetch_model.sv ----
// program memory fetch model handing out instruction words
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// fetch port
	input  wire logic        i_load,
	input  wire logic [15:0] i_word,
	input  wire logic        i_take,
	output logic             o_word_ok,
	output logic [15:0]      o_word
);
	logic [15:0] word_q;
	logic        full_q;
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			full_q <= 1'b0;
			word_q <= 16'h0;
		end else if (i_load) begin
			full_q <= 1'b1;
			word_q <= i_word;
		end else if (i_take) begin
			full_q <= 1'b0;
		end
	end
	// once taken the word is gone: show its inverse, never a stale copy
	assign o_word_ok = full_q;
	assign o_word = full_q ? word_q : ~word_q;
endmodule
`default_nettype wire

// ---- tb/test_ofd_core.sv ----
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module test_ofd_core;
	import ofd_pkg::*;
	logic        i_clk, i_rstn, fm_load, fm_take, fm_ok;
	logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
	logic        i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
	logic        i_s_axi_arvalid, i_s_axi_rready;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rv, e;
	logic [3:0]  i_s_axi_wstrb;
	logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
	logic        o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rs;
	logic [15:0] fm_word, fm_out;
	int          miscompares, num_checks;
	ofd_core ofd_core_inst (.*);
	ofd_fetch_model ofd_fetch_model_inst (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_load(fm_load), .i_word(fm_word), .i_take(fm_take),
		.o_word_ok(fm_ok), .o_word(fm_out));
	// ==========================================================
	// reporting
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, g);
		num_checks++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, x, g);
		end
	endtask
	// ==========================================================
	// bus master
	function automatic logic sig(input int k);
		case (k)
			0: return o_s_axi_awready;
			1: return o_s_axi_bvalid;
			2: return o_s_axi_arready;
			default: return o_s_axi_rvalid;
		endcase
	endfunction
	task automatic wt(input int k);
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (sig(k) !== 1'b1 && n < 64);
		if (sig(k) !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		wt(0);
		i_s_axi_awvalid <= 1'b0;
		i_s_axi_wvalid <= 1'b0;
		// ready raised late on purpose so the slave must hold its answer
		wt(1);
		i_s_axi_bready <= 1'b1;
		wt(1);
		rs = o_s_axi_bresp;
		i_s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		wt(2);
		i_s_axi_arvalid <= 1'b0;
		wt(3);
		i_s_axi_rready <= 1'b1;
		wt(3);
		rv = o_s_axi_rdata;
		rs = o_s_axi_rresp;
		i_s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [7:0] a,
		input logic [31:0] m, x);
		rd(a);
		chk(nm, x, rv & m);
	endtask
	task automatic ex(input logic [15:0] w);
		int n;
		logic [15:0] iw;
		fm_load <= 1'b1;
		fm_word <= w;
		@(posedge i_clk);
		fm_load <= 1'b0;
		@(posedge i_clk);
		// copy the word while it stands; the take edge empties the model
		iw = fm_out;
		chk("fetch_ok", 32'h1, {31'h0, fm_ok});
		chk("fetch_word", {16'h0, w}, {16'h0, iw});
		fm_take <= 1'b1;
		@(posedge i_clk);
		fm_take <= 1'b0;
		wr(8'h00, {16'h0, iw});
		rd(8'h34);
		chk("busy", 32'h1, {31'h0, rv[0]});
		for (n = 0; n < 20 && rv[0] !== 1'b0; n++)
			rd(8'h34);
		chk("polls", 32'h1, n);
		if (n >= 20)
			give_verdict();
	endtask
	// ==========================================================
	// expectations
	function automatic logic [11:0] fa(input logic [7:0] f,
		input logic [3:0] b, input logic a);
		if (a)
			return {b, f};
		return (f < 8'h80) ? {4'h0, f} : {4'hf, f};
	endfunction
	function automatic logic [4:0] fl(input logic [7:0] w, v);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, w} + {1'b0, v};
		h = {1'b0, w[3:0]} + {1'b0, v[3:0]};
		return {s[7], w[7] == v[7] && s[7] != w[7], s[7:0] == 8'h0,
			h[4], s[8]};
	endfunction
	// ==========================================================
	// stimulus
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial begin : main
		logic [7:0]  w, v, f, k;
		logic [3:0]  bk;
		logic        a, d;
		logic [20:0] p;
		logic [11:0] s12;
		logic [19:0] n20;
		logic [8:0]  s9;
		{i_rstn, fm_load, fm_take, i_s_axi_awvalid, i_s_axi_wvalid} = '0;
		{i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
		{i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, fm_word} = '0;
		i_s_axi_wstrb = 4'hf;
		void'($urandom(32'haae4));
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		rc("bank", 8'h08, 32'hf, 32'h0);
		rc("table_pointer", 8'h10, 32'h1fffff, 32'h0);
		rd(8'h40);
		chk("rresp", 32'h2, {30'h0, rs});
		wr(8'h40, 32'h0);
		chk("bresp", 32'h2, {30'h0, rs});
		wr(8'h1c, 32'h5a);
		i_s_axi_wstrb <= 4'he;
		wr(8'h1c, 32'hff);
		i_s_axi_wstrb <= 4'hf;
		rc("strobe", 8'h1c, 32'hff, 32'h5a);
		for (int i = 0; i < 10; i++) begin
			{w, v, bk} = 20'($urandom);
			f = (i < 2) ? 8'h7f + 8'(i) : 8'($urandom);
			a = (i < 4) ? 1'b0 : 1'($urandom);
			d = 1'(i);
			wr(8'h04, {24'h0, w});
			wr(8'h08, {28'h0, bk});
			wr(8'h1c, {24'h0, v});
			ex({6'b001001, d, a, f});
			s9 = {1'b0, w} + {1'b0, v};
			e = {16'h0, d, 3'h0, fa(f, bk, a)};
			rc("adr", 8'h20, 32'h8fff, e);
			rc("acc", 8'h04, 32'hff, d ? w : s9[7:0]);
			rc("file", 8'h1c, 32'hff, d ? s9[7:0] : v);
			rc("flags", 8'h0c, 32'h1f, fl(w, v));
		end
		for (int b = 0; b < 8; b++) begin
			{v, f} = 16'($urandom);
			wr(8'h1c, {24'h0, v});
			ex({3'b100, 1'(b), 3'(b), 1'b0, f});
			e = b[0] ? v & ~(8'h1 << b) : v | (8'h1 << b);
			rc("bit", 8'h1c, 32'hff, e);
			rc("bitpos", 8'h20, 32'h7000, {17'h0, 3'(b), 12'h0});
		end
		{w, v} = 16'($urandom);
		wr(8'h04, {24'h0, w});
		wr(8'h1c, {24'h0, v});
		ex({8'h02, f});
		rc("product", 8'h18, 32'hffff, 16'(w) * 16'(v));
		k = 8'($urandom);
		ex({8'h0e, k});
		rc("lit8", 8'h28, 32'h3fffff, {24'h0, k});
		n20 = 20'($urandom);
		ex({8'hef, n20[7:0]});
		ex({4'hf, n20[19:8]});
		rc("goto", 8'h38, 32'h1fffff, {11'h0, n20, 1'b0});
		rc("lit20", 8'h28, 32'h3fffff, {10'h2, n20});
		for (int q = 0; q < 4; q++) begin
			s12 = 12'($urandom);
			ex({10'b1110111000, 2'(q), s12[11:8]});
			ex({8'hf0, s12[7:0]});
			rc("lit12", 8'h28, 32'h3fffff, {10'h1, 8'h0, s12});
			rc("ptrsel", 8'h20, 32'h30000, {14'h0, 2'(q), 16'h0});
		end
		s12 = 12'($urandom);
		ex({4'hc, s12});
		ex(16'hffff);
		rc("move", 8'h24, 32'hffffff, {8'h0, 12'hfff, s12});
		for (int m = 0; m < 4; m++) begin
			p = (m == 1) ? 21'h1fffff : 21'($urandom);
			k = 8'($urandom);
			wr(8'h10, {11'h0, p});
			wr(8'h3c, {24'h0, k});
			ex({14'h2, 2'(m)});
			rc("latch", 8'h14, 32'hff, {24'h0, k});
			p = (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1;
			rc("table_pointer", 8'h10, 32'h1fffff, {11'h0, p});
			rc("step", 8'h34, 32'h30, {26'h0, 2'(m), 4'h0});
			k = 8'($urandom);
			wr(8'h14, {24'h0, k});
			ex({14'h3, 2'(m)});
			rc("prog", 8'h3c, 32'hff, {24'h0, k});
		end
		w = 8'($urandom);
		wr(8'h04, {24'h0, w});
		ex(16'hed00);
		ex(16'hf000);
		rc("shadow", 8'h30, 32'hff, {24'h0, w});
		wr(8'h04, {24'h0, ~w});
		ex(16'hec00);
		ex(16'hf000);
		rc("shadow", 8'h30, 32'hff, {24'h0, w});
		ex(16'h0012);
		rc("acc", 8'h04, 32'hff, {24'h0, ~w});
		ex(16'h0013);
		rc("acc", 8'h04, 32'hff, {24'h0, w});
		wr(8'h38, 32'h100);
		ex(16'hd7fd);
		rc("branch", 8'h38, 32'h1fffff, 32'hfc);
		wr(8'h38, 32'h40);
		ex(16'hf5a5);
		rc("lone", 8'h34, 32'h4, 32'h4);
		rc("pc", 8'h38, 32'h1fffff, 32'h42);
		rc("acc", 8'h04, 32'hff, {24'h0, w});
		give_verdict();
	end
endmodule
`default_nettype wire

// ---- verilog/ofd_core.sv ----
// operand field decoder core with its axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ofd_regs.svh"
module ofd_core (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// write address
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	// write data
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	// write response
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	// read address
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	// read data
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready
);
	import ofd_pkg::*;

	function automatic logic ofd_hit(input logic [7:0] a,
		input logic [3:0] r);
		return (a[7:6] == 2'h0) && (a[5:2] == r);
	endfunction

	function automatic logic [31:0] ofd_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction

	// data memory address from access bit, file operand and bank
	function automatic logic [11:0] ofd_dmem(input logic a,
		input logic [7:0] f, input logic [3:0] bank);
		if (a) begin
			return {bank, f};
		end
		if (f < `OFD_ACC_SPLIT) begin
			return {4'h0, f};
		end
		return {`OFD_ACC_HIBANK, f};
	endfunction

	// ==========================================================
	// state
	ofd_phase_t  phase_q;
	logic [3:0]  div_q;
	logic        osc_tick, ex;
	logic [15:0] instr_q, first_q;
	logic        pend_q, nop_q;
	logic [7:0]  acc_q, file_q, tbllat_q, prog_q;
	logic [3:0]  bank_q, sh_bank_q;
	logic [4:0]  flags_q, sh_flags_q;
	logic [7:0]  sh_acc_q;
	logic [20:0] table_pointer_q, pc_q;
	logic [15:0] prod_q;
	logic [11:0] addr_q, src_q, dst_q;
	logic [2:0]  bitpos_q;
	logic        dest_q;
	logic [1:0]  fsr_q, step_q;
	logic [19:0] lit_q;
	ofd_litw_t   litw_q;
	logic [6:0]  zs_q, zd_q;

	// ==========================================================
	// bus slave
	logic        bvalid_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [31:0] regv [0:15];
	logic        wr_en, rd_en;
	logic [31:0] wv;

	// both channels must be present; a lone one simply waits
	assign wr_en = i_s_axi_awvalid & i_s_axi_wvalid & ~bvalid_q;
	assign rd_en = i_s_axi_arvalid & ~rvalid_q;
	assign o_s_axi_awready = wr_en;
	assign o_s_axi_wready  = wr_en;
	assign o_s_axi_arready = rd_en;
	assign o_s_axi_bvalid  = bvalid_q;
	assign o_s_axi_bresp   = bresp_q;
	assign o_s_axi_rvalid  = rvalid_q;
	assign o_s_axi_rresp   = rresp_q;
	assign o_s_axi_rdata   = rdata_q;
	assign wv = ofd_merge(regv[i_s_axi_awaddr[5:2]], i_s_axi_wdata,
		i_s_axi_wstrb);

	always_comb begin
		regv[`OFD_R_INSTR]  = {16'h0, instr_q};
		regv[`OFD_R_ACC]    = {24'h0, acc_q};
		regv[`OFD_R_BANK]   = {28'h0, bank_q};
		regv[`OFD_R_FLAGS]  = {27'h0, flags_q};
		regv[`OFD_R_TABLE_POINTER] = {11'h0, table_pointer_q};
		regv[`OFD_R_TBLLAT] = {24'h0, tbllat_q};
		regv[`OFD_R_PROD]   = {16'h0, prod_q};
		regv[`OFD_R_FILE]   = {24'h0, file_q};
		regv[`OFD_R_ADDR]   = {14'h0, fsr_q, dest_q, bitpos_q, addr_q};
		regv[`OFD_R_MOVE]   = {8'h0, dst_q, src_q};
		regv[`OFD_R_LIT]    = {10'h0, litw_q, lit_q};
		regv[`OFD_R_INDEX]  = {17'h0, zd_q, 1'b0, zs_q};
		regv[`OFD_R_SHADOW] = {15'h0, sh_flags_q, sh_bank_q, sh_acc_q};
		regv[`OFD_R_STAT]   = {26'h0, step_q, 1'b0, nop_q, pend_q,
			phase_q != OFD_IDLE};
		regv[`OFD_R_PC]     = {11'h0, pc_q};
		regv[`OFD_R_PROG]   = {24'h0, prog_q};
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= 2'h0;
		end else if (wr_en) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (i_s_axi_awaddr[7:6] == 2'h0) ? 2'h0 : 2'h2;
		end else if (i_s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= 2'h0;
			rdata_q  <= 32'h0;
		end else if (rd_en) begin
			rvalid_q <= 1'b1;
			// unmapped reads answer slverr with zero data
			if (i_s_axi_araddr[7:6] == 2'h0) begin
				rresp_q <= 2'h0;
				rdata_q <= regv[i_s_axi_araddr[5:2]];
			end else begin
				rresp_q <= 2'h2;
				rdata_q <= 32'h0;
			end
		end else if (i_s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// instruction cycle sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			div_q <= 4'h0;
		end else if (osc_tick) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end
	assign osc_tick = (div_q == 4'(`OFD_OSC_CLKS - 1));
	assign ex = osc_tick && (phase_q == OFD_Q4);

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			phase_q <= OFD_IDLE;
		end else begin
			unique case (phase_q)
				OFD_IDLE: begin
					if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_INSTR)) begin
						phase_q <= OFD_Q1;
					end
				end
				OFD_Q1: if (osc_tick) phase_q <= OFD_Q2;
				OFD_Q2: if (osc_tick) phase_q <= OFD_Q3;
				OFD_Q3: if (osc_tick) phase_q <= OFD_Q4;
				OFD_Q4: if (osc_tick) phase_q <= OFD_IDLE;
				default: phase_q <= OFD_IDLE;
			endcase
		end
	end

	// words written while busy are dropped
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			instr_q <= 16'h0;
		end else if (wr_en && phase_q == OFD_IDLE &&
			ofd_hit(i_s_axi_awaddr, `OFD_R_INSTR)) begin
			instr_q <= wv[15:0];
		end
	end

	// ==========================================================
	// decode; only the bits each form defines are compared
	logic op_add, op_mul, op_bset, op_bclr, op_lit, op_tbl, op_ret;
	logic op_bra, op_first, is_sec, done2;
	logic f_movff, f_call, f_goto, f_lfsr, f_movs;
	logic [8:0]  sum9;
	logic [4:0]  sum_lo;
	logic [20:0] tbl_nx;

	assign op_add   = instr_q[15:10] == 6'b001001;
	assign op_mul   = instr_q[15:9] == 7'b0000001;
	assign op_bset  = instr_q[15:12] == 4'b1000;
	assign op_bclr  = instr_q[15:12] == 4'b1001;
	assign op_lit   = instr_q[15:8] == 8'h0e;
	assign op_tbl   = instr_q[15:3] == 13'h0001;
	assign op_ret   = instr_q[15:1] == 15'h0009;
	assign op_bra   = instr_q[15:11] == 5'b11010;
	assign op_first = instr_q[15:12] == 4'hc ||
		instr_q[15:9] == 7'b1110110 || instr_q[15:8] == 8'hef ||
		instr_q[15:6] == 10'b1110111000 || instr_q[15:8] == 8'heb;
	assign is_sec   = instr_q[15:12] == 4'hf;
	assign done2    = ex && pend_q && is_sec;
	assign f_movff  = first_q[15:12] == 4'hc;
	assign f_call   = first_q[15:9] == 7'b1110110;
	assign f_goto   = first_q[15:8] == 8'hef;
	assign f_lfsr   = first_q[15:6] == 10'b1110111000;
	assign f_movs   = first_q[15:8] == 8'heb;

	assign sum9   = {1'b0, acc_q} + {1'b0, file_q};
	assign sum_lo = {1'b0, acc_q[3:0]} + {1'b0, file_q[3:0]};
	always_comb begin
		unique case (ofd_step_t'(instr_q[1:0]))
			OFD_STEP_NONE: tbl_nx = table_pointer_q;
			OFD_STEP_PDEC: tbl_nx = table_pointer_q - 21'h1;
			default:       tbl_nx = table_pointer_q + 21'h1;
		endcase
	end

	// ==========================================================
	// two-word tracking; a stray second word is a no-operation
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pend_q  <= 1'b0;
			first_q <= 16'h0;
			nop_q   <= 1'b0;
		end else if (ex) begin
			pend_q  <= op_first;
			nop_q   <= is_sec && !pend_q;
			if (op_first) begin
				first_q <= instr_q;
			end
		end
	end

	// ==========================================================
	// operand field capture
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			addr_q   <= 12'h0;
			bitpos_q <= 3'h0;
			dest_q   <= 1'b0;
		end else if (ex && (op_add || op_mul || op_bset || op_bclr)) begin
			addr_q   <= ofd_dmem(instr_q[8], instr_q[7:0], bank_q);
			bitpos_q <= instr_q[11:9];
			dest_q   <= instr_q[9];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			src_q <= 12'h0;
			dst_q <= 12'h0;
			zs_q  <= 7'h0;
			zd_q  <= 7'h0;
			fsr_q <= 2'h0;
		end else if (done2) begin
			if (f_movff) begin
				src_q <= first_q[11:0];
				dst_q <= instr_q[11:0];
			end
			if (f_movs) begin
				zs_q <= first_q[6:0];
				if (first_q[7]) begin
					zd_q <= instr_q[6:0];
				end else begin
					dst_q <= instr_q[11:0];
				end
			end
			if (f_lfsr) begin
				fsr_q <= first_q[5:4];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			lit_q  <= 20'h0;
			litw_q <= OFD_LIT8;
		end else if (ex && op_lit) begin
			lit_q  <= {12'h0, instr_q[7:0]};
			litw_q <= OFD_LIT8;
		end else if (done2 && f_lfsr) begin
			lit_q  <= {8'h0, first_q[3:0], instr_q[7:0]};
			litw_q <= OFD_LIT12;
		end else if (done2 && (f_call || f_goto)) begin
			lit_q  <= {instr_q[11:0], first_q[7:0]};
			litw_q <= OFD_LIT20;
		end
	end

	// ==========================================================
	// program counter; one word is two bytes
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pc_q <= `OFD_RST_PTR;
		end else if (done2 && (f_call || f_goto)) begin
			pc_q <= {instr_q[11:0], first_q[7:0], 1'b0};
		end else if (ex && op_bra) begin
			pc_q <= pc_q + 21'h2 +
				{{9{instr_q[10]}}, instr_q[10:0], 1'b0};
		end else if (ex) begin
			pc_q <= pc_q + 21'h2;
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_PC)) begin
			pc_q <= wv[20:0];
		end
	end

	// ==========================================================
	// core registers; execution wins over a bus write
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			acc_q <= `OFD_RST_BYTE;
		end else if (ex && op_lit) begin
			acc_q <= instr_q[7:0];
		end else if (ex && op_add && !instr_q[9]) begin
			acc_q <= sum9[7:0];
		end else if (ex && op_ret && instr_q[0]) begin
			acc_q <= sh_acc_q;
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_ACC)) begin
			acc_q <= wv[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			file_q <= `OFD_RST_BYTE;
		end else if (ex && op_add && instr_q[9]) begin
			file_q <= sum9[7:0];
		end else if (ex && (op_bset || op_bclr)) begin
			file_q[instr_q[11:9]] <= op_bset;
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_FILE)) begin
			file_q <= wv[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			bank_q <= `OFD_RST_BANK;
		end else if (ex && op_ret && instr_q[0]) begin
			bank_q <= sh_bank_q;
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_BANK)) begin
			bank_q <= wv[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			flags_q <= `OFD_RST_FLAGS;
		end else if (ex && op_add) begin
			flags_q[`OFD_F_C]  <= sum9[8];
			flags_q[`OFD_F_DC] <= sum_lo[4];
			flags_q[`OFD_F_Z]  <= sum9[7:0] == 8'h00;
			flags_q[`OFD_F_OV] <= (acc_q[7] == file_q[7]) &&
				(sum9[7] != acc_q[7]);
			flags_q[`OFD_F_N]  <= sum9[7];
		end else if (ex && op_ret && instr_q[0]) begin
			flags_q <= sh_flags_q;
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_FLAGS)) begin
			flags_q <= wv[4:0];
		end
	end

	// shadows move only on a fast call
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			sh_acc_q   <= `OFD_RST_BYTE;
			sh_bank_q  <= `OFD_RST_BANK;
			sh_flags_q <= `OFD_RST_FLAGS;
		end else if (done2 && f_call && first_q[8]) begin
			sh_acc_q   <= acc_q;
			sh_bank_q  <= bank_q;
			sh_flags_q <= flags_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			prod_q <= 16'h0;
		end else if (ex && op_mul) begin
			prod_q <= 16'(acc_q) * 16'(file_q);
		end
	end

	// ==========================================================
	// table transfers against the program byte register
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			table_pointer_q <= `OFD_RST_PTR;
			step_q   <= 2'h0;
		end else if (ex && op_tbl) begin
			table_pointer_q <= tbl_nx;
			step_q   <= instr_q[1:0];
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_TABLE_POINTER)) begin
			table_pointer_q <= wv[20:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tbllat_q <= `OFD_RST_BYTE;
		end else if (ex && op_tbl && !instr_q[2]) begin
			tbllat_q <= prog_q;
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_TBLLAT)) begin
			tbllat_q <= wv[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			prog_q <= `OFD_RST_BYTE;
		end else if (ex && op_tbl && instr_q[2]) begin
			prog_q <= tbllat_q;
		end else if (wr_en && ofd_hit(i_s_axi_awaddr, `OFD_R_PROG)) begin
			prog_q <= wv[7:0];
		end
	end
endmodule
`default_nettype wire

// ---- verilog/ofd_pkg.sv ----
// types shared by the operand field decoder
package ofd_pkg;
	typedef enum logic [4:0] {
		OFD_IDLE = 5'h01,
		OFD_Q1   = 5'h02,
		OFD_Q2   = 5'h04,
		OFD_Q3   = 5'h08,
		OFD_Q4   = 5'h10
	} ofd_phase_t;
	typedef enum logic [1:0] {
		OFD_STEP_NONE = 2'h0,
		OFD_STEP_PINC = 2'h1,
		OFD_STEP_PDEC = 2'h2,
		OFD_STEP_PRE  = 2'h3
	} ofd_step_t;
	typedef enum logic [1:0] {
		OFD_LIT8  = 2'h0,
		OFD_LIT12 = 2'h1,
		OFD_LIT20 = 2'h2
	} ofd_litw_t;
endpackage

// ---- verilog/ofd_regs.svh ----
// register offsets, field positions, reset values and timing counts
// Operation
// - access bit clear: access RAM, bank ignored
// - access bit set: bank select forms address
// - three-bit field picks bit zero to seven
// - destination bit: accumulator or file register
// - file operand is eight-bit address
// - pointer load uses two-bit pointer selector
// - register move source is twelve bits
// - register move target is twelve bits
// - literals are 8, 12 or 20 bits
// - two-bit table pointer step mode field
// - relative branches signed, call/goto absolute
// - fast bit clear leaves shadows alone
// - fast bit set saves/restores shadow copies
// - twenty-one-bit table pointer
// - don't-care bits never change decoding
// - seven-bit source and target index offsets
// - five ALU status flags kept
// - product split into high and low bytes
// - lone second word runs as no-operation
// - instruction cycle is four oscillator periods
`ifndef OFD_REGS_SVH
`define OFD_REGS_SVH
// ==========================================================
// register word indices (byte address = index * 4)
`define OFD_R_INSTR   4'h0
`define OFD_R_ACC     4'h1
`define OFD_R_BANK    4'h2
`define OFD_R_FLAGS   4'h3
`define OFD_R_TABLE_POINTER  4'h4
`define OFD_R_TBLLAT  4'h5
`define OFD_R_PROD    4'h6
`define OFD_R_FILE    4'h7
`define OFD_R_ADDR    4'h8
`define OFD_R_MOVE    4'h9
`define OFD_R_LIT     4'ha
`define OFD_R_INDEX   4'hb
`define OFD_R_SHADOW  4'hc
`define OFD_R_STAT    4'hd
`define OFD_R_PC      4'he
`define OFD_R_PROG    4'hf
// ==========================================================
// flag positions
`define OFD_F_C   0
`define OFD_F_DC  1
`define OFD_F_Z   2
`define OFD_F_OV  3
`define OFD_F_N   4
// ==========================================================
// reset values and access region split
`define OFD_RST_BYTE    8'h00
`define OFD_RST_BANK    4'h0
`define OFD_RST_FLAGS   5'h00
`define OFD_RST_PTR     21'h000000
`define OFD_ACC_SPLIT   8'h80
`define OFD_ACC_HIBANK  4'hf
// ==========================================================
// timing
`define OFD_CLK_NS      5
`define OFD_OSC_NS      5
`define OFD_OSC_CLKS    (`OFD_OSC_NS / `OFD_CLK_NS)
`endif
